// ---- crac_pkg.sv ----
// constants, types and field layouts shared by the addressing block
// assumes a 100 MHz core clock and frames decoded on that same clock
//
// How it works
// - no assignment when a fixed address is set
// - random address is 24 bits wide
// - result commands return a reply frame
// - react per class, one address each
// - each functional unit owns its addresses
// - terminate ends addressing, but while a pair is pending it only cancels the pair
// - initialize needs second copy within 100 ms
// - other command between copies cancels both
// - accepted initialize (re)starts 15 minute window
// - addressing commands only inside the window
// - initialize obeys the frame's address byte
// - randomize needs an uninterrupted pair too
// - new random address ready within 100 ms
// - compare replies yes when random <= search
// - withdraw drops matching unit from compares
// - search address bytes set by three codes
// - random address bytes returned by three queries
// - program short address, 255 deletes it
`default_nettype none

package crac_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned PAIR_WIN_MS  = 100;
  localparam int unsigned ADDR_WIN_MIN = 15;
  localparam logic [31:0] PAIR_WIN_CYC = 32'(PAIR_WIN_MS * (CLK_HZ / 1000));
  localparam logic [39:0] ADDR_WIN_CYC = 40'(ADDR_WIN_MIN) * 40'd60 * 40'(CLK_HZ);

  localparam logic [7:0] OP_TERM   = 8'h1a;
  localparam logic [7:0] OP_INIT   = 8'h1b;
  localparam logic [7:0] OP_RAND   = 8'h1c;
  localparam logic [7:0] OP_CMP    = 8'h1d;
  localparam logic [7:0] OP_WDRAW  = 8'h1e;
  localparam logic [7:0] OP_SRCH_H = 8'h1f;
  localparam logic [7:0] OP_SRCH_M = 8'h20;
  localparam logic [7:0] OP_SRCH_L = 8'h21;
  localparam logic [7:0] OP_PROG   = 8'h22;
  localparam logic [7:0] OP_QRY_H  = 8'h26;
  localparam logic [7:0] OP_QRY_M  = 8'h27;
  localparam logic [7:0] OP_QRY_L  = 8'h28;

  localparam logic [7:0] REPLY_YES    = 8'h01;
  localparam logic [7:0] SHORT_DELETE = 8'hff;
  localparam logic [7:0] ADDR_BCAST   = 8'hff;
  localparam logic [1:0] ADDR_TAG_IND = 2'b00;
  localparam logic [1:0] ADDR_TAG_TYP = 2'b10;

  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RANDOM = 12'h008;
  localparam logic [11:0] OFS_SEARCH = 12'h00c;
  localparam logic [11:0] OFS_SHORT  = 12'h010;

  localparam int unsigned CTRL_FIXED_BIT = 0;
  localparam int unsigned CTRL_CLASS_LSB = 8;
  localparam logic [5:0]  CLASS_RST      = 6'h00;
  localparam logic [23:0] LFSR_SEED      = 24'h5a3c71;
  localparam logic [23:0] LFSR_TAPS      = 24'he10000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] data;
  } crac_frame_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } crac_reply_type;

  typedef enum logic [2:0] {
    PAIR_IDLE = 3'b001,
    PAIR_INIT = 3'b010,
    PAIR_RAND = 3'b100
  } crac_pair_type;

endpackage : crac_pkg

`default_nettype wire

// ---- crac_timer.sv ----
// one-shot down counter with restart and stop
// assumes start and stop are single-cycle pulses on core_clk_i
`timescale 1ns/1ps
`default_nettype none

module crac_timer #(
  parameter int unsigned W = 32
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic         start_i,
  input  wire logic         stop_i,
  input  wire logic [W-1:0] load_i,
  output logic              running_o,
  output logic              expire_o
);

  logic [W-1:0] count_r;
  logic         last_w;

  assign last_w = running_o && count_r == W'(1);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r   <= '0;
      running_o <= 1'b0;
      expire_o  <= 1'b0;
    end else begin
      expire_o <= last_w && !start_i && !stop_i;
      if (start_i) begin
        count_r   <= load_i;
        running_o <= 1'b1;
      end else if (stop_i || last_w) begin
        count_r   <= '0;
        running_o <= 1'b0;
      end else if (running_o) begin
        count_r <= count_r - W'(1);
      end
    end
  end

endmodule : crac_timer

`default_nettype wire

// ---- crac_lfsr.sv ----
// free-running 24-bit pseudo random source
// assumes the user samples state_o whenever a fresh value is needed
`timescale 1ns/1ps
`default_nettype none

module crac_lfsr (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        stir_i,
  output logic [23:0]      state_o
);

  logic [23:0] state_nxt;

  // galois shift, stir_i perturbs the sequence with bus activity
  assign state_nxt = {1'b0, state_o[23:1]}
                   ^ (state_o[0] ? crac_pkg::LFSR_TAPS : 24'h000000)
                   ^ {23'h000000, stir_i};

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_o <= crac_pkg::LFSR_SEED;
    end else begin
      state_o <= (state_nxt == 24'h000000) ? crac_pkg::LFSR_SEED : state_nxt;
    end
  end

endmodule : crac_lfsr

`default_nettype wire

// ---- crac_top.sv ----
// random individual address assignment for one functional unit, with apb registers
// assumes decoded 3-byte frames arrive on core_clk_i, one-cycle frame_valid_i
`timescale 1ns/1ps
`default_nettype none

module crac_top #(
  parameter logic [31:0] PAIR_CYC = crac_pkg::PAIR_WIN_CYC,
  parameter logic [39:0] WIN_CYC  = crac_pkg::ADDR_WIN_CYC
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  input  wire logic                     frame_valid_i,
  input  wire crac_pkg::crac_frame_type frame_i,
  output crac_pkg::crac_reply_type      reply_o,
  output logic                          initialized_o
);

  // software controls and unit state
  logic                    fixed_r;
  logic [5:0]              class_r;
  logic                    withdrawn_r;
  logic [23:0]             random_r;
  logic [23:0]             search_r;
  logic [7:0]              short_r;
  logic                    short_valid_r;
  crac_pkg::crac_pair_type pair_r;
  crac_pkg::crac_pair_type pair_nxt;

  // timers and random source
  logic                    pair_run;
  logic                    pair_exp;
  logic                    win_run;
  logic                    win_exp;
  logic [23:0]             lfsr_val;

  // frame decode
  logic                    hit_bcast;
  logic                    hit_type;
  logic                    hit_indiv;
  logic                    cmd_take;
  logic                    st_idle;
  logic                    plain;
  logic                    live;
  logic                    first_init;
  logic                    first_rand;
  logic                    init_ok;
  logic                    rand_ok;
  logic                    term_ok;
  logic                    addr_match;
  logic                    rand_le;
  logic [7:0]              op;
  logic                    do_wdraw;
  logic                    do_srch_h;
  logic                    do_srch_m;
  logic                    do_srch_l;
  logic                    do_prog;
  logic                    do_cmp_yes;
  logic                    do_qry_h;
  logic                    do_qry_m;
  logic                    do_qry_l;
  logic                    short_keep;
  logic                    reply_fire;
  logic [7:0]              reply_pick;
  logic                    pair_start;
  logic                    pair_stop;
  logic                    win_clear;

  assign op = frame_i.opcode;

  assign hit_bcast  = frame_i.addr == crac_pkg::ADDR_BCAST;
  assign hit_type   = frame_i.addr[7:6] == crac_pkg::ADDR_TAG_TYP
                   && frame_i.addr[5:0] == class_r;
  assign hit_indiv  = frame_i.addr[7:6] == crac_pkg::ADDR_TAG_IND && short_valid_r
                   && frame_i.addr[5:0] == short_r[5:0];
  assign cmd_take   = frame_valid_i && !fixed_r
                   && (hit_bcast || hit_type || hit_indiv);

  assign st_idle    = pair_r == crac_pkg::PAIR_IDLE;
  assign plain      = cmd_take && st_idle;
  assign live       = plain && initialized_o;

  assign first_init = plain && op == crac_pkg::OP_INIT;
  assign first_rand = live && op == crac_pkg::OP_RAND;
  assign init_ok    = cmd_take && pair_run && pair_r == crac_pkg::PAIR_INIT
                   && op == crac_pkg::OP_INIT;
  assign rand_ok    = cmd_take && pair_run && pair_r == crac_pkg::PAIR_RAND
                   && op == crac_pkg::OP_RAND;
  assign term_ok    = plain && op == crac_pkg::OP_TERM;

  assign addr_match = random_r == search_r;
  assign rand_le    = random_r <= search_r;

  // addressing command decode, all gated by the open window
  assign do_wdraw   = live && op == crac_pkg::OP_WDRAW && addr_match;
  assign do_srch_h  = live && op == crac_pkg::OP_SRCH_H;
  assign do_srch_m  = live && op == crac_pkg::OP_SRCH_M;
  assign do_srch_l  = live && op == crac_pkg::OP_SRCH_L;
  assign do_prog    = live && op == crac_pkg::OP_PROG && addr_match;
  assign do_cmp_yes = live && op == crac_pkg::OP_CMP && !withdrawn_r && rand_le;
  assign do_qry_h   = live && op == crac_pkg::OP_QRY_H;
  assign do_qry_m   = live && op == crac_pkg::OP_QRY_M;
  assign do_qry_l   = live && op == crac_pkg::OP_QRY_L;
  assign short_keep = frame_i.data != crac_pkg::SHORT_DELETE;
  assign reply_fire = do_cmp_yes || do_qry_h || do_qry_m || do_qry_l;
  assign reply_pick = do_cmp_yes ? crac_pkg::REPLY_YES
                    : do_qry_h   ? random_r[23:16]
                    : do_qry_m   ? random_r[15:8]
                    : random_r[7:0];

  // a selected frame during a pending pair ends the pair and is dropped unless it is the matching second copy
  assign pair_start = first_init || first_rand;
  assign pair_stop  = cmd_take && !st_idle;
  assign win_clear  = term_ok || win_exp;

  // pair tracking: any selected command while waiting closes the pair
  always_comb begin
    pair_nxt = pair_r;
    case (pair_r)
      crac_pkg::PAIR_IDLE: begin
        if (first_init) begin
          pair_nxt = crac_pkg::PAIR_INIT;
        end else if (first_rand) begin
          pair_nxt = crac_pkg::PAIR_RAND;
        end
      end
      crac_pkg::PAIR_INIT,
      crac_pkg::PAIR_RAND: begin
        if (cmd_take || pair_exp) begin
          pair_nxt = crac_pkg::PAIR_IDLE;
        end
      end
      default: begin
        pair_nxt = crac_pkg::PAIR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pair_r <= crac_pkg::PAIR_IDLE;
    end else begin
      pair_r <= pair_nxt;
    end
  end

  // pair timer bounds the gap between the two copies of a paired command
  crac_timer #(
    .W (32)
  ) u_pair_timer (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (pair_start),
    .stop_i     (pair_stop),
    .load_i     (PAIR_CYC),
    .running_o  (pair_run),
    .expire_o   (pair_exp)
  );

  // window timer, restarted by every accepted initialize
  crac_timer #(
    .W (40)
  ) u_win_timer (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .start_i    (init_ok),
    .stop_i     (term_ok),
    .load_i     (WIN_CYC),
    .running_o  (win_run),
    .expire_o   (win_exp)
  );

  // lfsr runs freely; random_r only snapshots it on a completed randomize
  crac_lfsr u_lfsr (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .stir_i     (frame_valid_i),
    .state_o    (lfsr_val)
  );

  // addressing state: window membership and withdrawal
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      initialized_o <= 1'b0;
      withdrawn_r   <= 1'b0;
    end else begin
      if (init_ok) begin
        initialized_o <= 1'b1;
        withdrawn_r   <= 1'b0;
      end else if (win_clear) begin
        initialized_o <= 1'b0;
        withdrawn_r   <= 1'b0;
      end else if (do_wdraw) begin
        withdrawn_r <= 1'b1;
      end
    end
  end

  // addressing state: random, search and short addresses
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      random_r      <= 24'hffffff;
      search_r      <= 24'hffffff;
      short_r       <= crac_pkg::SHORT_DELETE;
      short_valid_r <= 1'b0;
    end else begin
      if (rand_ok) begin
        random_r <= lfsr_val;
      end
      if (do_srch_h) begin
        search_r[23:16] <= frame_i.data;
      end
      if (do_srch_m) begin
        search_r[15:8] <= frame_i.data;
      end
      if (do_srch_l) begin
        search_r[7:0] <= frame_i.data;
      end
      if (do_prog) begin
        short_r       <= frame_i.data;
        short_valid_r <= short_keep;
      end
    end
  end

  // replies to result commands, one cycle after the frame
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reply_o <= '0;
    end else begin
      reply_o.valid <= reply_fire;
      if (reply_fire) begin
        reply_o.data <= reply_pick;
      end
    end
  end

  // apb slave, one wait state per access
  logic        apb_access;
  logic        apb_done;
  logic        apb_first;
  logic        apb_wr;
  logic        sel_ctrl;
  logic        sel_status;
  logic        sel_random;
  logic        sel_search;
  logic        sel_short;
  logic        sel_any;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  assign apb_access  = psel_i && penable_i;
  assign apb_done    = apb_access && pready_o;
  assign apb_first   = apb_access && !pready_o;
  assign sel_ctrl    = paddr_i == crac_pkg::OFS_CTRL;
  assign sel_status  = paddr_i == crac_pkg::OFS_STATUS;
  assign sel_random  = paddr_i == crac_pkg::OFS_RANDOM;
  assign sel_search  = paddr_i == crac_pkg::OFS_SEARCH;
  assign sel_short   = paddr_i == crac_pkg::OFS_SHORT;
  assign sel_any     = sel_ctrl || sel_status || sel_random || sel_search || sel_short;
  assign apb_wr      = apb_done && pwrite_i && sel_ctrl;

  assign status_word = {26'h0000000, win_run, !st_idle, short_valid_r,
                        pair_run, withdrawn_r, initialized_o};
  assign rd_word     = sel_ctrl   ? {18'h00000, class_r, 7'h00, fixed_r}
                     : sel_status ? status_word
                     : sel_random ? {8'h00, random_r}
                     : sel_search ? {8'h00, search_r}
                     : sel_short  ? {23'h000000, short_valid_r, short_r}
                     : 32'h00000000;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= apb_first;
      pslverr_o <= apb_first && !sel_any;
      // read data is latched in the first access cycle so it stands with pready_o
      if (apb_first && !pwrite_i) begin
        prdata_o <= rd_word;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fixed_r <= 1'b0;
      class_r <= crac_pkg::CLASS_RST;
    end else if (apb_wr) begin
      fixed_r <= pwdata_i[crac_pkg::CTRL_FIXED_BIT];
      class_r <= pwdata_i[crac_pkg::CTRL_CLASS_LSB +: 6];
    end
  end

endmodule : crac_top

`default_nettype wire

// ---- crac_master_model.sv ----
// frame source standing in for the bus master
// assumes the caller orders pairs and spaces them inside the pair window
`timescale 1ns/1ps
`default_nettype none
module crac_master_model (
  input  wire logic                    core_clk_i,
  output var crac_pkg::crac_frame_type frame_o,
  output var logic                     frame_valid_o
);
  initial begin
    frame_valid_o = 1'b0;
    frame_o       = '0;
  end
  // one whole frame per call, lines scrambled while idle
  task automatic send(input logic [7:0] a, input logic [7:0] o, input logic [7:0] d);
    @(posedge core_clk_i);
    frame_valid_o <= 1'b1;
    frame_o       <= {a, o, d};
    @(posedge core_clk_i);
    frame_valid_o <= 1'b0;
    frame_o       <= ~{a, o, d};
  endtask : send
endmodule : crac_master_model
`default_nettype wire

// ---- crac_checker.sv ----
// port-level assertions for the addressing block
// assumes binding to crac_top
`timescale 1ns/1ps
`default_nettype none
module crac_checker (
  input wire logic                     core_clk_i,
  input wire logic                     reset_n_i,
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pwrite_i,
  input wire logic [31:0]              prdata_o,
  input wire logic                     pready_o,
  input wire logic                     pslverr_o,
  input wire logic                     frame_valid_i,
  input wire crac_pkg::crac_frame_type frame_i,
  input wire crac_pkg::crac_reply_type reply_o,
  input wire logic                     initialized_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic [7:0] op = frame_i.opcode;
  wire logic       qry = op == crac_pkg::OP_QRY_H || op == crac_pkg::OP_QRY_M
                         || op == crac_pkg::OP_QRY_L;
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_cmp;
    frame_valid_i && op == crac_pkg::OP_CMP ##1 reply_o.valid;
  endsequence
  a_ready_wait: assert property (s_access |=> pready_o)
    else $error("pready late");
  a_ready_one: assert property (pready_o |=> !pready_o)
    else $error("pready too long");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_err_rdata: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("error read data not zero");
  a_reply_cause: assert property (reply_o.valid |-> $past(frame_valid_i)
    && ($past(op) == crac_pkg::OP_CMP || $past(qry))) else $error("reply without cause");
  a_cmp_yes: assert property (s_cmp |-> reply_o.data == crac_pkg::REPLY_YES)
    else $error("compare reply not yes");
  a_reply_idle: assert property (frame_valid_i && !initialized_o |=> !reply_o.valid)
    else $error("reply outside window");
  a_init_cause: assert property ($rose(initialized_o) |-> $past(frame_valid_i)
    && $past(op) == crac_pkg::OP_INIT) else $error("window opened without init");
  a_reply_hold: assert property (!reply_o.valid |-> $stable(reply_o.data))
    else $error("reply data moved");
endmodule : crac_checker
bind crac_top crac_checker u_crac_checker (.core_clk_i, .reset_n_i, .psel_i, .penable_i,
  .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .frame_valid_i, .frame_i, .reply_o,
  .initialized_o);
`default_nettype wire

// ---- crac_tb_top.sv ----
// self-checking bench for crac_top
// assumes short pair and window counts set below
`timescale 1ns/1ps
`default_nettype none
module crac_tb_top;
  logic                     clk, rst_n, psel, pen, pwr, pready, perr, fv, init_st, qe;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, q;
  logic [23:0]              r0, rnd;
  logic [7:0]               last_rep;
  crac_pkg::crac_frame_type fr;
  crac_pkg::crac_reply_type rep;
  int                       n_fail, total_checks, n_rep;
  crac_top #(.PAIR_CYC(32'd20), .WIN_CYC(40'd200)) u_crac_top (.core_clk_i(clk),
    .reset_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .frame_valid_i(fv), .frame_i(fr), .reply_o(rep), .initialized_o(init_st));
  crac_master_model u_crac_master_model (.core_clk_i(clk), .frame_o(fr), .frame_valid_o(fv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rep.valid === 1'b1) begin
    n_rep    <= n_rep + 1;
    last_rep <= rep.data;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q    = prdata;
    qe   = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task f(input logic [7:0] a, input logic [7:0] o, input logic [7:0] d);
    u_crac_master_model.send(a, o, d);
    cyc(2);
  endtask : f
  task pair(input logic [7:0] a, input logic [7:0] o);
    f(a, o, 8'h00);
    cyc(3);
    f(a, o, 8'h00);
  endtask : pair
  task ask_at(input logic [7:0] a, input logic [7:0] o, input logic [7:0] e, input int n);
    int n0;
    n0 = n_rep;
    f(a, o, 8'h00);
    chk(32'(n_rep - n0), 32'(n));
    if (n > 0) chk({24'h0, last_rep}, {24'h0, e});
  endtask : ask_at
  task ask(input logic [7:0] o, input logic [7:0] e, input int n);
    ask_at(8'hff, o, e, n);
  endtask : ask
  task srch(input logic [23:0] v);
    f(8'hff, crac_pkg::OP_SRCH_H, v[23:16]);
    f(8'hff, crac_pkg::OP_SRCH_M, v[15:8]);
    f(8'hff, crac_pkg::OP_SRCH_L, v[7:0]);
  endtask : srch
  task t_regs;
    apb(1'b0, crac_pkg::OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, crac_pkg::OFS_RANDOM, 32'h0);
    chk(q, 32'hffffff);
    apb(1'b0, 12'h014, 32'h0);
    chk({q[30:0], qe}, 32'h1);
    ask(crac_pkg::OP_CMP, 8'h00, 0);
    $display("test regs done");
  endtask : t_regs
  task t_init;
    pair(8'hff, crac_pkg::OP_INIT);
    chk(32'(init_st), 32'h1);
    f(8'hff, crac_pkg::OP_TERM, 8'h00);
    chk(32'(init_st), 32'h0);
    f(8'hff, crac_pkg::OP_INIT, 8'h00);
    f(8'hff, crac_pkg::OP_SRCH_H, 8'h00);
    f(8'hff, crac_pkg::OP_INIT, 8'h00);
    chk(32'(init_st), 32'h0);
    cyc(30);
    f(8'hff, crac_pkg::OP_INIT, 8'h00);
    cyc(30);
    f(8'hff, crac_pkg::OP_INIT, 8'h00);
    chk(32'(init_st), 32'h0);
    cyc(30);
    apb(1'b1, crac_pkg::OFS_CTRL, 32'h1);
    pair(8'hff, crac_pkg::OP_INIT);
    chk(32'(init_st), 32'h0);
    apb(1'b1, crac_pkg::OFS_CTRL, 32'h300);
    pair(8'h81, crac_pkg::OP_INIT);
    chk(32'(init_st), 32'h0);
    pair(8'h83, crac_pkg::OP_INIT);
    chk(32'(init_st), 32'h1);
    apb(1'b1, crac_pkg::OFS_CTRL, 32'h0);
    $display("test init done");
  endtask : t_init
  task t_search;
    srch(24'h123456);
    apb(1'b0, crac_pkg::OFS_SEARCH, 32'h0);
    chk(q, 32'h123456);
    apb(1'b0, crac_pkg::OFS_RANDOM, 32'h0);
    r0 = q[23:0];
    f(8'hff, crac_pkg::OP_RAND, 8'h00);
    f(8'hff, crac_pkg::OP_SRCH_H, 8'h00);
    f(8'hff, crac_pkg::OP_RAND, 8'h00);
    cyc(25);
    apb(1'b0, crac_pkg::OFS_SEARCH, 32'h0);
    chk(q, 32'h123456);
    apb(1'b0, crac_pkg::OFS_RANDOM, 32'h0);
    chk(q, {8'h0, r0});
    pair(8'hff, crac_pkg::OP_RAND);
    apb(1'b0, crac_pkg::OFS_RANDOM, 32'h0);
    rnd = q[23:0];
    chk(32'(rnd !== r0), 32'h1);
    srch(rnd);
    ask(crac_pkg::OP_CMP, crac_pkg::REPLY_YES, 1);
    ask(crac_pkg::OP_QRY_H, rnd[23:16], 1);
    ask(crac_pkg::OP_QRY_M, rnd[15:8], 1);
    ask(crac_pkg::OP_QRY_L, rnd[7:0], 1);
    srch(rnd - 24'h1);
    ask(crac_pkg::OP_CMP, 8'h00, 0);
    srch(rnd);
    f(8'hff, crac_pkg::OP_WDRAW, 8'h00);
    apb(1'b0, crac_pkg::OFS_STATUS, 32'h0);
    chk({30'h0, q[1:0]}, 32'h3);
    ask(crac_pkg::OP_CMP, 8'h00, 0);
    f(8'hff, crac_pkg::OP_PROG, 8'h05);
    apb(1'b0, crac_pkg::OFS_SHORT, 32'h0);
    chk({23'h0, q[8:0]}, 32'h105);
    ask_at(8'h05, crac_pkg::OP_QRY_L, rnd[7:0], 1);
    f(8'hff, crac_pkg::OP_PROG, 8'hff);
    apb(1'b0, crac_pkg::OFS_SHORT, 32'h0);
    chk(32'(q[8]), 32'h0);
    ask_at(8'h05, crac_pkg::OP_QRY_L, 8'h00, 0);
    $display("test search done");
  endtask : t_search
  task t_window;
    pair(8'hff, crac_pkg::OP_INIT);
    cyc(150);
    pair(8'hff, crac_pkg::OP_INIT);
    cyc(150);
    chk(32'(init_st), 32'h1);
    cyc(100);
    chk(32'(init_st), 32'h0);
    ask(crac_pkg::OP_QRY_H, 8'h00, 0);
    $display("test window done");
  endtask : t_window
  initial begin
    #100us;
    n_fail++;
    give_verdict;
  end
  initial begin
    {rst_n, psel, pen, pwr, paddr, pwdata} = '0;
    {n_fail, total_checks, n_rep} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_regs;
    t_init;
    t_search;
    t_window;
    give_verdict;
  end
endmodule : crac_tb_top
`default_nettype wire
